// file: hdl/pm_defines.vh
// constants of the sleep mode power controller
// assumes a 40 MHz system clock (25 ns period)
`ifndef PM_DEFINES_VH
`define PM_DEFINES_VH

// ****************************************
// sleep mode select codes
// ****************************************
`define PM_MODE_IDLE     3'h0
`define PM_MODE_ADCNR    3'h1
`define PM_MODE_PDOWN    3'h2
`define PM_MODE_PSAVE    3'h3
`define PM_MODE_RSVD4    3'h4
`define PM_MODE_RSVD5    3'h5
`define PM_MODE_STBY     3'h6
`define PM_MODE_XSTBY    3'h7

// ****************************************
// controller states
// ****************************************
`define PM_ST_ACTIVE     2'h0
`define PM_ST_SLEEP      2'h1
`define PM_ST_WAKE       2'h2
`define PM_ST_HALT       2'h3

// ****************************************
// timing
// ****************************************
`define PM_CLK_PERIOD_NS 25
`define PM_BOD_WAKE_NS   60000
// bod wake stretch: 60 us at 25 ns, sized to the wake timer
`define PM_BOD_WAKE_CYC  16'h0960
`define PM_STBY_WAKE_CYC 16'h0006
`define PM_IRQ_HALT_CYC  16'h0004
`define PM_UNLOCK_CYC    3'h4
`define PM_BOD_OFF_IN_SLEEP_DLY_CYC  3'h3
`define PM_BOD_OFF_IN_SLEEP_HOLD_CYC 3'h3

// ****************************************
// reset values and fuse codes
// ****************************************
`define PM_BOD_OFF_IN_SLEEP_RESET    1'b0
`define PM_BOD_FUSE_OFF  3'h7

`endif

// file: hdl/pin_sync3.v
// three-stage synchroniser with agreement filter for asynchronous inputs
// assumes inputs come from pins or async modules outside sys_clk
`timescale 1ns/1ps

module pin_sync3 #(
	parameter W = 4
) (
	// clock and reset
	input  wire         sys_clk_i,
	input  wire         reset_n_i,
	// data
	input  wire [W-1:0] async_i,
	output reg  [W-1:0] sync_o
);

reg [W-1:0] s1_ff;
reg [W-1:0] s2_ff;
reg [W-1:0] s3_ff;

// ****************************************
// stages
// ****************************************
always @(posedge sys_clk_i) begin
	if (!reset_n_i) begin
		s1_ff  <= {W{1'b0}};
		s2_ff  <= {W{1'b0}};
		s3_ff  <= {W{1'b0}};
		sync_o <= {W{1'b0}};
	end else begin
		s1_ff <= async_i;
		s2_ff <= s1_ff;
		s3_ff <= s2_ff;
		if (s2_ff == s3_ff) begin
			sync_o <= s3_ff;
		end
	end
end

endmodule

// file: hdl/wake_timer.v
// loadable down counter for wake-up and halt delays
// assumes load values of at least one cycle
`timescale 1ns/1ps

module wake_timer #(
	parameter W = 16
) (
	// clock and reset
	input  wire         sys_clk_i,
	input  wire         reset_n_i,
	// control
	input  wire         load_i,
	input  wire [W-1:0] load_val_i,
	output wire         done_o
);

reg [W-1:0] cnt_ff;

// ****************************************
// counter
// ****************************************
always @(posedge sys_clk_i) begin
	if (!reset_n_i) begin
		cnt_ff <= {W{1'b0}};
	end else if (load_i) begin
		cnt_ff <= load_val_i;
	end else if (cnt_ff != {W{1'b0}}) begin
		cnt_ff <= cnt_ff - 1'b1;
	end
end

assign done_o = (cnt_ff <= {{(W-1){1'b0}}, 1'b1});

endmodule

// file: hdl/sleep_mode_power_controller.v
// sleep mode and power reduction controller: mode entry, clock gating,
// wake-up sources, wake delays, software bod disable, peripheral stop
// assumes the core gives a one-cycle pulse per sleep instruction and
// external/watchdog/brown-out resets arrive as the system reset
//
// Behaviour
// RULE1: code 000 enters idle, stopping only cpu and flash clocks.
// RULE2: idle wakes on external and internal interrupts.
// RULE3: entering idle or adc noise reduction with adc enabled starts a conversion.
// RULE4: code 001 enters adc noise reduction, halting io, cpu, flash clocks.
// RULE5: adc noise reduction wakes only on its listed events.
// RULE6: in adc noise reduction timer runs only when asynchronously clocked.
// RULE7: code 010 enters power-down, stopping oscillator and generated clocks.
// RULE8: power-down wakes only on resets, watchdog, address match, level, pin change.
// RULE9: level wake source gone before start-up end: wake without interrupt.
// RULE10: wake from power-down waits the fuse-defined reset time-out.
// RULE11: code 011 is power-save; enabled timer 2 runs and may wake.
// RULE12: in power-save main clock runs while touch controller enabled.
// RULE13: power-save stops unused timer 2 clocks; sync clock feeds timer 2 only.
// RULE14: code 110 with crystal is standby; oscillator runs, six-cycle wake.
// RULE15: code 111 with crystal is extended standby; six-cycle wake.
// RULE16: software bod disable cuts bod in sleep, restores it on wake.
// RULE17: after sleep with bod cut, wake takes about 60 us.
// RULE18: bod off bit zero keeps bod on; one cuts it where allowed.
// RULE19: clock-stop bit freezes peripheral and blocks its register access.
// RULE20: peripheral clock stop applies in active and idle only.
// RULE21: adc stays enabled in sleep; re-enable makes next conversion extended.
// RULE22: comparator off in deep sleep unless it uses internal reference.
// RULE23: sleep needs sleep enable set; codes 100 and 101 reserved.
// RULE24: bod off bit needs unlock sequence, delay three, clears after three.
// RULE25: interrupt wake halts four extra cycles before the handler runs.
// RULE26: sleep with a reserved code is ignored; execution continues.
`timescale 1ns/1ps
`include "pm_defines.vh"

module sleep_mode_power_controller #(
	parameter PRR_W = 8,
	parameter TW    = 16
) (
	// clock and reset
	input  wire             sys_clk_i,
	input  wire             reset_n_i,
	// core sleep control
	input  wire             sleep_instr_i,
	input  wire             sleep_entry_enable_i,
	input  wire [2:0]       sleep_mode_select_i,
	input  wire             xtal_option_i,
	input  wire [TW-1:0]    startup_cycles_i,
	// core control register writes
	input  wire             ctrl_wr_i,
	input  wire             wr_bod_off_i,
	input  wire             wr_bod_unlock_i,
	input  wire [2:0]       bod_threshold_fuses_i,
	// asynchronous wake sources
	input  wire             ext_level_irq_i,
	input  wire             pin_change_irq_i,
	input  wire             twi_addr_match_i,
	input  wire             wdt_irq_i,
	// synchronous wake sources
	input  wire             adc_done_i,
	input  wire             timer_irq_i,
	input  wire             spm_ready_i,
	input  wire             other_irq_i,
	input  wire             t2_ovf_i,
	input  wire             t2_cmp_i,
	input  wire [1:0]       timer2_irq_mask_i,
	input  wire             global_irq_en_i,
	// peripheral configuration
	input  wire             t2_enable_i,
	input  wire             t2_async_i,
	input  wire             t2_sync_i,
	input  wire             touch_enable_i,
	input  wire             adc_enable_i,
	input  wire             comparator_uses_ref_i,
	input  wire [PRR_W-1:0] peripheral_clock_stop_0_i,
	input  wire [PRR_W-1:0] peripheral_clock_stop_1_i,
	// clock domain enables
	output reg              cpu_clk_en_o,
	output reg              flash_clk_en_o,
	output reg              io_clk_en_o,
	output reg              adc_clk_en_o,
	output reg              asy_clk_en_o,
	output reg              touch_clk_en_o,
	output reg              main_osc_en_o,
	output reg              timer_osc_en_o,
	output reg              sync_t2_only_o,
	output reg              t2_run_o,
	output reg  [PRR_W-1:0] periph_clk_en_0_o,
	output reg  [PRR_W-1:0] periph_clk_en_1_o,
	output reg  [PRR_W-1:0] periph_access_block_0_o,
	output reg  [PRR_W-1:0] periph_access_block_1_o,
	// analog control
	output reg              bod_en_o,
	output reg              comparator_power_off_o,
	output reg              adc_start_o,
	output reg              adc_extended_o,
	// core status
	output reg              core_halt_o,
	output reg              sleeping_o,
	output reg              wake_irq_o,
	output reg              bod_off_in_sleep_o
);

// ****************************************
// declarations
// ****************************************
reg  [1:0] state_ff;
reg  [1:0] nxt_state;
reg  [2:0] mode_ff;
reg  [2:0] nxt_mode;
reg        bod_cut_ff;
reg        nxt_bod_cut;
reg        irq_src_ff;
reg        nxt_irq_src;
reg        lvl_src_ff;
reg        nxt_lvl_src;
reg  [2:0] unlock_cnt_ff;
reg  [2:0] bod_off_in_sleep_dly_ff;
reg  [2:0] bod_off_in_sleep_hold_ff;
reg        adc_en_d_ff;
reg        tmr_load;
reg  [TW-1:0] tmr_val;
reg  [TW-1:0] dly;
reg        wake_evt;
reg        nxt_adc_start;
reg        nxt_wake_irq;
wire       tmr_done;
wire [3:0] async_sync;
wire       lvl_s;
wire       pin_s;
wire       twi_s;
wire       wdt_s;
wire       mode_ok;
wire       deep;
wire       t2_evt;
wire       bod_fuse_on;
wire       sleeping;

assign lvl_s       = async_sync[0];
assign pin_s       = async_sync[1];
assign twi_s       = async_sync[2];
assign wdt_s       = async_sync[3];
assign bod_fuse_on = (bod_threshold_fuses_i != `PM_BOD_FUSE_OFF);
assign sleeping    = (state_ff == `PM_ST_SLEEP);
assign deep        = (mode_ff != `PM_MODE_IDLE) && (mode_ff != `PM_MODE_ADCNR);

// ****************************************
// submodules
// ****************************************
pin_sync3 #(
	.W (4)
) u_sync (
	.sys_clk_i (sys_clk_i),
	.reset_n_i (reset_n_i),
	.async_i   ({wdt_irq_i, twi_addr_match_i, pin_change_irq_i, ext_level_irq_i}),
	.sync_o    (async_sync)
);

wake_timer #(
	.W (TW)
) u_timer (
	.sys_clk_i  (sys_clk_i),
	.reset_n_i  (reset_n_i),
	.load_i     (tmr_load),
	.load_val_i (tmr_val),
	.done_o     (tmr_done)
);

// ****************************************
// mode qualification
// ****************************************
// RULE23: reserved codes rejected
// RULE26: reserved code ignored
// RULE14: standby needs crystal
// RULE15: extended standby needs crystal
assign mode_ok = (sleep_mode_select_i == `PM_MODE_IDLE)
	|| (sleep_mode_select_i == `PM_MODE_ADCNR)
	|| (sleep_mode_select_i == `PM_MODE_PDOWN)
	|| (sleep_mode_select_i == `PM_MODE_PSAVE)
	|| (((sleep_mode_select_i == `PM_MODE_STBY)
	|| (sleep_mode_select_i == `PM_MODE_XSTBY)) && xtal_option_i);

// RULE11: timer 2 wake gating
assign t2_evt = t2_enable_i && global_irq_en_i
	&& ((t2_ovf_i && timer2_irq_mask_i[0]) || (t2_cmp_i && timer2_irq_mask_i[1]));

// ****************************************
// bod off unlock sequence
// ****************************************
// RULE24: timed write sequence
// RULE18: bit defaults to bod on
always @(posedge sys_clk_i) begin
	if (!reset_n_i) begin
		unlock_cnt_ff      <= 3'h0;
		bod_off_in_sleep_dly_ff        <= 3'h0;
		bod_off_in_sleep_hold_ff       <= 3'h0;
		bod_off_in_sleep_o <= `PM_BOD_OFF_IN_SLEEP_RESET;
	end else begin
		if (ctrl_wr_i && wr_bod_off_i && wr_bod_unlock_i) begin
			unlock_cnt_ff <= `PM_UNLOCK_CYC;
		end else if (unlock_cnt_ff != 3'h0) begin
			unlock_cnt_ff <= unlock_cnt_ff - 3'h1;
		end
		if (ctrl_wr_i && wr_bod_off_i && !wr_bod_unlock_i && (unlock_cnt_ff != 3'h0)) begin
			bod_off_in_sleep_dly_ff <= `PM_BOD_OFF_IN_SLEEP_DLY_CYC;
		end else if (bod_off_in_sleep_dly_ff != 3'h0) begin
			bod_off_in_sleep_dly_ff <= bod_off_in_sleep_dly_ff - 3'h1;
		end
		if (bod_off_in_sleep_dly_ff == 3'h1) begin
			bod_off_in_sleep_hold_ff       <= `PM_BOD_OFF_IN_SLEEP_HOLD_CYC;
			bod_off_in_sleep_o <= 1'b1;
		end else if (bod_off_in_sleep_hold_ff > 3'h1) begin
			bod_off_in_sleep_hold_ff <= bod_off_in_sleep_hold_ff - 3'h1;
		end else begin
			bod_off_in_sleep_hold_ff       <= 3'h0;
			bod_off_in_sleep_o <= 1'b0;
		end
	end
end

// ****************************************
// wake source selection
// ****************************************
always @* begin
	wake_evt = 1'b0;
	case (mode_ff)
	// RULE2: idle wakes on any interrupt
	`PM_MODE_IDLE: begin
		wake_evt = lvl_s || pin_s || twi_s || wdt_s || adc_done_i || timer_irq_i
			|| spm_ready_i || other_irq_i || t2_evt;
	end
	// RULE5: noise reduction sources
	`PM_MODE_ADCNR: begin
		wake_evt = adc_done_i || lvl_s || pin_s || twi_s || wdt_s
			|| (timer_irq_i && t2_async_i) || spm_ready_i;
	end
	// RULE8: power-down sources
	`PM_MODE_PDOWN, `PM_MODE_STBY: begin
		wake_evt = lvl_s || pin_s || twi_s || wdt_s;
	end
	// RULE11: power-save adds timer 2
	`PM_MODE_PSAVE, `PM_MODE_XSTBY: begin
		wake_evt = lvl_s || pin_s || twi_s || wdt_s || t2_evt;
	end
	default: begin
		wake_evt = 1'b0;
	end
	endcase
end

// ****************************************
// wake delay
// ****************************************
always @* begin
	dly = {{(TW-1){1'b0}}, 1'b1};
	case (mode_ff)
	`PM_MODE_IDLE, `PM_MODE_ADCNR: begin
		dly = {{(TW-1){1'b0}}, 1'b1};
	end
	// RULE14: six cycles from standby
	// RULE15: six cycles from extended standby
	`PM_MODE_STBY, `PM_MODE_XSTBY: begin
		dly = `PM_STBY_WAKE_CYC;
	end
	// RULE10: fuse-defined restart time
	default: begin
		dly = (startup_cycles_i == {TW{1'b0}}) ? {{(TW-1){1'b0}}, 1'b1} : startup_cycles_i;
	end
	endcase
	// RULE17: stretch for bod settling
	if (bod_cut_ff && (dly < `PM_BOD_WAKE_CYC)) begin
		dly = `PM_BOD_WAKE_CYC;
	end
end

// ****************************************
// sleep state machine
// ****************************************
always @* begin
	nxt_state     = state_ff;
	nxt_mode      = mode_ff;
	nxt_bod_cut   = bod_cut_ff;
	nxt_irq_src   = irq_src_ff;
	nxt_lvl_src   = lvl_src_ff;
	nxt_adc_start = 1'b0;
	nxt_wake_irq  = 1'b0;
	tmr_load      = 1'b0;
	tmr_val       = dly;
	case (state_ff)
	`PM_ST_ACTIVE: begin
		// RULE23: sleep enable required
		if (sleep_instr_i && sleep_entry_enable_i && mode_ok) begin
			nxt_state   = `PM_ST_SLEEP;
			nxt_mode    = sleep_mode_select_i;
			// RULE16: cut bod on entry
			nxt_bod_cut = bod_off_in_sleep_o && bod_fuse_on
				&& (sleep_mode_select_i != `PM_MODE_IDLE)
				&& (sleep_mode_select_i != `PM_MODE_ADCNR);
			// RULE3: auto conversion start
			nxt_adc_start = adc_enable_i && ((sleep_mode_select_i == `PM_MODE_IDLE)
				|| (sleep_mode_select_i == `PM_MODE_ADCNR));
		end
	end
	`PM_ST_SLEEP: begin
		if (wake_evt) begin
			nxt_state   = `PM_ST_WAKE;
			tmr_load    = 1'b1;
			nxt_lvl_src = lvl_s;
			nxt_irq_src = wake_evt && !(lvl_s && !(pin_s || twi_s || wdt_s
				|| adc_done_i || timer_irq_i || spm_ready_i || other_irq_i || t2_evt));
		end
	end
	`PM_ST_WAKE: begin
		if (tmr_done) begin
			// RULE16: bod back on wake
			nxt_bod_cut = 1'b0;
			// RULE9: vanished level gives no interrupt
			if (irq_src_ff || (lvl_src_ff && lvl_s)) begin
				nxt_state = `PM_ST_HALT;
				tmr_load  = 1'b1;
				tmr_val   = `PM_IRQ_HALT_CYC;
			end else begin
				nxt_state = `PM_ST_ACTIVE;
			end
		end
	end
	`PM_ST_HALT: begin
		// RULE25: four-cycle halt then handler
		if (tmr_done) begin
			nxt_state    = `PM_ST_ACTIVE;
			nxt_wake_irq = 1'b1;
		end
	end
	default: begin
		nxt_state = `PM_ST_ACTIVE;
	end
	endcase
end

always @(posedge sys_clk_i) begin
	if (!reset_n_i) begin
		state_ff    <= `PM_ST_ACTIVE;
		mode_ff     <= `PM_MODE_IDLE;
		bod_cut_ff  <= 1'b0;
		irq_src_ff  <= 1'b0;
		lvl_src_ff  <= 1'b0;
		adc_start_o <= 1'b0;
		wake_irq_o  <= 1'b0;
	end else begin
		state_ff    <= nxt_state;
		mode_ff     <= nxt_mode;
		bod_cut_ff  <= nxt_bod_cut;
		irq_src_ff  <= nxt_irq_src;
		lvl_src_ff  <= nxt_lvl_src;
		adc_start_o <= nxt_adc_start;
		wake_irq_o  <= nxt_wake_irq;
	end
end

// ****************************************
// clock gating outputs
// ****************************************
always @(posedge sys_clk_i) begin
	if (!reset_n_i) begin
		cpu_clk_en_o            <= 1'b1;
		flash_clk_en_o          <= 1'b1;
		io_clk_en_o             <= 1'b1;
		adc_clk_en_o            <= 1'b1;
		asy_clk_en_o            <= 1'b1;
		touch_clk_en_o          <= 1'b1;
		main_osc_en_o           <= 1'b1;
		timer_osc_en_o          <= 1'b0;
		sync_t2_only_o          <= 1'b0;
		t2_run_o                <= 1'b1;
		periph_clk_en_0_o       <= {PRR_W{1'b1}};
		periph_clk_en_1_o       <= {PRR_W{1'b1}};
		periph_access_block_0_o <= {PRR_W{1'b0}};
		periph_access_block_1_o <= {PRR_W{1'b0}};
		core_halt_o             <= 1'b0;
		sleeping_o              <= 1'b0;
		bod_en_o                <= 1'b0;
		comparator_power_off_o  <= 1'b0;
	end else begin
		core_halt_o <= (nxt_state != `PM_ST_ACTIVE);
		sleeping_o  <= (nxt_state == `PM_ST_SLEEP);
		// RULE18: bod follows fuses and sleep cut
		bod_en_o <= bod_fuse_on && !nxt_bod_cut;
		// RULE19: frozen peripheral blocks access
		periph_access_block_0_o <= peripheral_clock_stop_0_i;
		periph_access_block_1_o <= peripheral_clock_stop_1_i;
		if (nxt_state != `PM_ST_SLEEP) begin
			// running or restarting: cpu held until active
			cpu_clk_en_o           <= (nxt_state == `PM_ST_ACTIVE);
			flash_clk_en_o         <= (nxt_state == `PM_ST_ACTIVE);
			io_clk_en_o            <= 1'b1;
			adc_clk_en_o           <= 1'b1;
			asy_clk_en_o           <= 1'b1;
			touch_clk_en_o         <= 1'b1;
			main_osc_en_o          <= 1'b1;
			timer_osc_en_o         <= t2_async_i;
			sync_t2_only_o         <= 1'b0;
			t2_run_o               <= 1'b1;
			comparator_power_off_o <= 1'b0;
			// RULE20: clock stop in active
			periph_clk_en_0_o <= ~peripheral_clock_stop_0_i;
			periph_clk_en_1_o <= ~peripheral_clock_stop_1_i;
		end else begin
			cpu_clk_en_o   <= 1'b0;
			flash_clk_en_o <= 1'b0;
			// RULE1: idle keeps io clock
			// RULE4: noise reduction halts io
			io_clk_en_o    <= (nxt_mode == `PM_MODE_IDLE);
			// RULE21: adc clock kept where mode runs it
			adc_clk_en_o   <= (nxt_mode == `PM_MODE_IDLE) || (nxt_mode == `PM_MODE_ADCNR);
			// RULE7: power-down and standby stop generated clocks
			case (nxt_mode)
			`PM_MODE_IDLE: begin
				asy_clk_en_o   <= 1'b1;
				touch_clk_en_o <= 1'b1;
				main_osc_en_o  <= 1'b1;
				timer_osc_en_o <= t2_async_i;
				sync_t2_only_o <= 1'b0;
				t2_run_o       <= 1'b1;
			end
			`PM_MODE_ADCNR: begin
				asy_clk_en_o   <= 1'b1;
				touch_clk_en_o <= 1'b1;
				main_osc_en_o  <= 1'b1;
				timer_osc_en_o <= t2_async_i;
				sync_t2_only_o <= 1'b0;
				// RULE6: async timer only
				t2_run_o       <= t2_async_i;
			end
			`PM_MODE_PSAVE, `PM_MODE_XSTBY: begin
				// RULE13: unused timer 2 clocks stopped
				asy_clk_en_o   <= t2_enable_i && t2_async_i;
				timer_osc_en_o <= t2_enable_i && t2_async_i;
				// RULE12: touch keeps main clock
				// RULE15: oscillator kept running
				touch_clk_en_o <= touch_enable_i;
				main_osc_en_o  <= touch_enable_i || (t2_enable_i && t2_sync_i)
					|| (nxt_mode == `PM_MODE_XSTBY);
				// RULE13: sync clock only to timer 2
				sync_t2_only_o <= t2_enable_i && t2_sync_i;
				t2_run_o       <= t2_enable_i;
			end
			default: begin
				// RULE14: standby keeps oscillator
				asy_clk_en_o   <= 1'b0;
				touch_clk_en_o <= 1'b0;
				main_osc_en_o  <= (nxt_mode == `PM_MODE_STBY);
				timer_osc_en_o <= 1'b0;
				sync_t2_only_o <= 1'b0;
				t2_run_o       <= 1'b0;
			end
			endcase
			// RULE20: stop bits only matter in idle
			if (nxt_mode == `PM_MODE_IDLE) begin
				periph_clk_en_0_o <= ~peripheral_clock_stop_0_i;
				periph_clk_en_1_o <= ~peripheral_clock_stop_1_i;
			end else begin
				periph_clk_en_0_o <= {PRR_W{1'b0}};
				periph_clk_en_1_o <= {PRR_W{1'b0}};
			end
			// RULE22: comparator off in deep sleep
			comparator_power_off_o <= (nxt_mode != `PM_MODE_IDLE)
				&& (nxt_mode != `PM_MODE_ADCNR) && !comparator_uses_ref_i;
		end
	end
end

// ****************************************
// extended conversion tracking
// ****************************************
always @(posedge sys_clk_i) begin
	if (!reset_n_i) begin
		adc_en_d_ff    <= 1'b0;
		adc_extended_o <= 1'b1;
	end else begin
		adc_en_d_ff <= adc_enable_i;
		// RULE21: re-enable forces extended conversion
		if (adc_enable_i && !adc_en_d_ff) begin
			adc_extended_o <= 1'b1;
		end else if (adc_done_i) begin
			adc_extended_o <= 1'b0;
		end
	end
end

endmodule

// file: sim/pm_wake_src.sv
// wake source model: an external level interrupt line held for a set time
// assumes fire and hold come from the bench off the falling edge
`timescale 1ns/1ps

module pm_wake_src (
	// clock
	input  wire logic       sys_clk_i,
	// control
	input  wire logic       fire_i,
	input  wire logic [7:0] hold_i,
	// wake line
	output logic            level_o
);
	logic [7:0] cnt_ff = 8'h00;
	initial level_o = 1'b0;
	always @(negedge sys_clk_i) begin
		if (fire_i) begin
			cnt_ff <= hold_i;
			level_o <= 1'b1;
		end else if (cnt_ff > 8'h01) begin
			cnt_ff <= cnt_ff - 8'h01;
		end else begin
			cnt_ff <= 8'h00;
			level_o <= 1'b0;
		end
	end
endmodule

// file: sim/pm_checker.sv
// checker of the sleep mode power controller ports
// assumes it is bound to the top module with its default widths
`timescale 1ns/1ps
`include "pm_defines.vh"

module pm_checker (
	// clock and reset
	input wire logic       sys_clk_i,
	input wire logic       reset_n_i,
	// requests
	input wire logic       sleep_instr_i,
	input wire logic       sleep_entry_enable_i,
	input wire logic [2:0] sleep_mode_select_i,
	input wire logic       adc_enable_i,
	input wire logic       comparator_uses_ref_i,
	input wire logic       ctrl_wr_i,
	input wire logic       wr_bod_off_i,
	input wire logic       wr_bod_unlock_i,
	// responses
	input wire logic       cpu_clk_en_o,
	input wire logic       flash_clk_en_o,
	input wire logic       io_clk_en_o,
	input wire logic       adc_clk_en_o,
	input wire logic       main_osc_en_o,
	input wire logic       comparator_power_off_o,
	input wire logic       adc_start_o,
	input wire logic       core_halt_o,
	input wire logic       sleeping_o,
	input wire logic       wake_irq_o,
	input wire logic       bod_off_in_sleep_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	wire go = sleep_instr_i && sleep_entry_enable_i && !core_halt_o;
	wire [2:0] sm = sleep_mode_select_i;
	sequence unlock_s;
		ctrl_wr_i && wr_bod_off_i && wr_bod_unlock_i;
	endsequence
	sequence arm_s;
		ctrl_wr_i && wr_bod_off_i && !wr_bod_unlock_i;
	endsequence
	idle_entry_a: assert property (go && sm == `PM_MODE_IDLE
		|=> sleeping_o && !cpu_clk_en_o && !flash_clk_en_o && io_clk_en_o)
		else $error("idle entry clocks wrong");
	adcnr_entry_a: assert property (go && sm == `PM_MODE_ADCNR
		|=> sleeping_o && !io_clk_en_o && !cpu_clk_en_o && adc_clk_en_o)
		else $error("adc noise entry clocks wrong");
	pdown_entry_a: assert property (go && sm == `PM_MODE_PDOWN
		|=> sleeping_o && !main_osc_en_o && !io_clk_en_o && !adc_clk_en_o)
		else $error("power-down entry clocks wrong");
	rsvd_ignore_a: assert property (go && sm[2:1] == 2'h2
		|=> !sleeping_o && !core_halt_o) else $error("reserved code slept");
	sleep_gate_a: assert property (sleep_instr_i && !sleep_entry_enable_i
		&& !core_halt_o |=> !sleeping_o) else $error("slept without enable");
	adc_start_a: assert property (go && adc_enable_i && sm <= `PM_MODE_ADCNR
		|=> adc_start_o ##1 !adc_start_o) else $error("adc start pulse wrong");
	irq_halt_a: assert property (wake_irq_o |-> !core_halt_o
		&& $past(core_halt_o, 4) && !$past(sleeping_o, 4)) else $error("irq halt wrong");
	bod_off_in_sleep_seq_a: assert property (unlock_s ##2 arm_s
		|-> ##4 bod_off_in_sleep_o [*3] ##1 !bod_off_in_sleep_o)
		else $error("bod off window wrong");
	comp_off_a: assert property (sleeping_o && !adc_clk_en_o
		&& !comparator_uses_ref_i |-> comparator_power_off_o) else $error("comparator on");
endmodule

bind sleep_mode_power_controller pm_checker chk_u (.*);

// file: sim/testbench.sv
// self-checking bench of the sleep mode power controller
// assumes the wake source model and checker are compiled before it
`timescale 1ns/1ps
`include "pm_defines.vh"

module testbench;
	logic sys_clk_i = 0, reset_n_i = 0, sleep_instr_i = 0, sleep_entry_enable_i = 1;
	logic xtal_option_i = 0, ctrl_wr_i = 0, wr_bod_off_i = 0, wr_bod_unlock_i = 0;
	logic pin_change_irq_i = 0, twi_addr_match_i = 0, wdt_irq_i = 0, adc_done_i = 0;
	logic timer_irq_i = 0, spm_ready_i = 0, other_irq_i = 0, t2_ovf_i = 0, t2_cmp_i = 0;
	logic global_irq_en_i = 1, t2_enable_i = 0, t2_async_i = 0, t2_sync_i = 0;
	logic touch_enable_i = 0, adc_enable_i = 1, comparator_uses_ref_i = 0, fire = 0;
	logic [2:0] sleep_mode_select_i = 3'h0, bod_threshold_fuses_i = 3'h0;
	logic [15:0] startup_cycles_i = 16'h0003;
	logic [1:0] timer2_irq_mask_i = 2'h0;
	logic [7:0] peripheral_clock_stop_0_i = 8'h00, peripheral_clock_stop_1_i = 8'h00, hold = 8'h00;
	wire ext_level_irq_i, cpu_clk_en_o, flash_clk_en_o, io_clk_en_o, adc_clk_en_o, asy_clk_en_o;
	wire touch_clk_en_o, main_osc_en_o, timer_osc_en_o, sync_t2_only_o, t2_run_o, bod_en_o;
	wire comparator_power_off_o, adc_start_o, adc_extended_o, core_halt_o, sleeping_o;
	wire wake_irq_o, bod_off_in_sleep_o;
	wire [7:0] periph_clk_en_0_o, periph_clk_en_1_o, periph_access_block_0_o, periph_access_block_1_o;
	int n_fail = 0, cmp_count = 0, n;
	logic irq;

	always #12.5 sys_clk_i = ~sys_clk_i;

	sleep_mode_power_controller dut_u (.*);
	pm_wake_src src_u (.sys_clk_i, .fire_i(fire), .hold_i(hold), .level_o(ext_level_irq_i));

	// ****************************************
	// tasks
	// ****************************************
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task tick(input int k);
		repeat (k) @(negedge sys_clk_i);
	endtask
	task slp(input logic [2:0] m);
		tick(1);
		sleep_instr_i = 1;
		sleep_mode_select_i = m;
		tick(1);
		sleep_instr_i = 0;
	endtask
	task automatic pulse(ref logic s);
		tick(1);
		s = 1;
		tick(1);
		s = 0;
	endtask
	task cw(input logic o, input logic u);
		tick(1);
		ctrl_wr_i = 1;
		wr_bod_off_i = o;
		wr_bod_unlock_i = u;
		tick(1);
		ctrl_wr_i = 0;
	endtask
	task fire_src(input logic [7:0] h);
		tick(1);
		hold <= h;
		fire <= 1;
		tick(1);
		fire <= 0;
	endtask
	task wt;
		n = 0;
		irq = 0;
		while (core_halt_o !== 1'b0 && n < 5000) begin
			@(posedge sys_clk_i);
			#1;
			n++;
			if (wake_irq_o === 1'b1) irq = 1;
		end
		chk("wake", 1, n < 5000);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	initial begin
		#(25 * 30000);
		n_fail++;
		final_report;
	end

	// ****************************************
	// tests
	// ****************************************
	initial begin
		tick(5);
		reset_n_i = 1;
		chk("adc_ext", 1, adc_extended_o);
		peripheral_clock_stop_0_i = 8'h5a;
		peripheral_clock_stop_1_i = 8'h81;
		tick(2);
		chk("pce0", 8'ha5, periph_clk_en_0_o);
		chk("pce1", 8'h7e, periph_clk_en_1_o);
		chk("pab0", 8'h5a, periph_access_block_0_o);
		chk("pab1", 8'h81, periph_access_block_1_o);
		pulse(adc_done_i);
		adc_enable_i = 0;
		tick(1);
		chk("adc_ext", 0, adc_extended_o);
		adc_enable_i = 1;
		tick(2);
		chk("adc_ext", 1, adc_extended_o);
		$display("test periph done");
		slp(`PM_MODE_IDLE);
		chk("adc_start", 1, adc_start_o);
		chk("io_en", 1, io_clk_en_o);
		pulse(timer_irq_i);
		wt;
		chk("idle_irq", 1, irq);
		chk("halt_len", 1, n >= 5);
		slp(`PM_MODE_ADCNR);
		chk("io_en", 0, io_clk_en_o);
		chk("nr_t2run", 0, t2_run_o);
		pulse(other_irq_i);
		tick(3);
		chk("nr_asleep", 1, sleeping_o);
		pulse(adc_done_i);
		wt;
		chk("nr_irq", 1, irq);
		$display("test idle_nr done");
		startup_cycles_i = 16'h0028;
		slp(`PM_MODE_PDOWN);
		chk("bod_en", 1, bod_en_o);
		chk("pd_asy", 0, asy_clk_en_o);
		pulse(timer_irq_i);
		tick(3);
		chk("pd_asleep", 1, sleeping_o);
		fire_src(8'h3c);
		wt;
		chk("pd_irq", 1, irq);
		chk("pd_delay", 1, n >= 40);
		tick(20);
		slp(`PM_MODE_PDOWN);
		fire_src(8'h06);
		wt;
		chk("short_lvl", 0, irq);
		sleep_entry_enable_i = 0;
		slp(`PM_MODE_IDLE);
		chk("no_se", 0, sleeping_o);
		sleep_entry_enable_i = 1;
		for (int m = 4; m < 8; m++) begin
			slp(m[2:0]);
			chk("refused", 0, sleeping_o);
		end
		$display("test pdown done");
		xtal_option_i = 1;
		for (int m = 6; m < 8; m++) begin
			slp(m[2:0]);
			chk("stby_osc", 1, main_osc_en_o);
			pin_change_irq_i = 1;
			wt;
			tick(1);
			pin_change_irq_i = 0;
			tick(4);
			chk("stby_fast", 1, n < 20);
		end
		t2_enable_i = 1;
		touch_enable_i = 1;
		slp(`PM_MODE_PSAVE);
		chk("ps_osc", 1, main_osc_en_o);
		chk("ps_touch", 1, touch_clk_en_o);
		chk("ps_tosc", 0, timer_osc_en_o);
		chk("ps_sync", 0, sync_t2_only_o);
		chk("ps_t2run", 1, t2_run_o);
		pulse(t2_ovf_i);
		tick(3);
		chk("ps_masked", 1, sleeping_o);
		timer2_irq_mask_i = 2'h1;
		pulse(t2_ovf_i);
		wt;
		chk("ps_irq", 1, irq);
		$display("test standby done");
		cw(1, 1);
		tick(5);
		cw(1, 0);
		tick(4);
		chk("late_arm", 0, bod_off_in_sleep_o);
		cw(1, 1);
		cw(1, 0);
		tick(2);
		slp(`PM_MODE_PDOWN);
		chk("bod_cut", 0, bod_en_o);
		fire_src(8'h3c);
		wt;
		chk("bod_delay", 1, n >= `PM_BOD_WAKE_CYC);
		chk("bod_back", 1, bod_en_o);
		$display("test bod done");
		final_report;
	end
endmodule
